//--- rtl/twi_target_defs.vh
// constants for the two-wire memory and register target port
`ifndef TWI_TARGET_DEFS_VH
`define TWI_TARGET_DEFS_VH
`define MEM_DEVICE_TYPE 4'ha
`define REG_DEVICE_TYPE 4'hd
`define TYPE_MSB 7
`define TYPE_LSB 4
`define SEL_MSB 2
`define SEL_LSB 1
`define RW_BIT 0
`define REG_ADDR_LAST 8'h18
`define MEM_ADDR_WIDTH 15
`define MEM_ADDR_RESET 15'h0000
`define REG_ADDR_RESET 5'h00
`define REG_COUNT 25
`endif

//--- rtl/line_sync.v
// two-flop synchroniser with edge and condition detection for scl and sda
`timescale 1ns/100ps
module line_sync (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// bus lines from pins
	input wire scl_in,
	input wire sda_in,
	// conditioned outputs
	output reg scl,
	output reg sda,
	output wire scl_rise,
	output wire scl_fall,
	output wire start_seen,
	output wire stop_seen
);
	reg scl_meta;
	reg sda_meta;
	reg scl_prev;
	reg sda_prev;

	always @(posedge sys_clk) begin
		if (rst) begin
			scl_meta <= 1'b1;
			sda_meta <= 1'b1;
			scl <= 1'b1;
			sda <= 1'b1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_meta <= scl_in;
			sda_meta <= sda_in;
			scl <= scl_meta;
			sda <= sda_meta;
			scl_prev <= scl;
			sda_prev <= sda;
		end
	end

	assign scl_rise = scl & ~scl_prev;
	assign scl_fall = ~scl & scl_prev;
	// sda moving while scl stays high marks a bus condition
	assign start_seen = scl & scl_prev & sda_prev & ~sda;
	assign stop_seen = scl & scl_prev & ~sda_prev & sda;
endmodule

//--- rtl/byte_store.v
// single-port byte array written directly, one byte at a time
`timescale 1ns/100ps
module byte_store #(
	parameter ADDR_WIDTH = 15,
	parameter DEPTH = 32768
) (
	// clock
	input wire sys_clk,
	// access port
	input wire [ADDR_WIDTH-1:0] addr,
	input wire write,
	input wire [7:0] wdata,
	output reg [7:0] rdata
);
	reg [7:0] cells [0:DEPTH-1];

	// no page buffer: each write lands in the cell at once
	always @(posedge sys_clk) begin
		if (write) begin
			cells[addr] <= wdata;
		end
		rdata <= cells[addr];
	end
endmodule

//--- rtl/twi_target.v
// two-wire target port for a byte memory and a small register space
//
// Summary of operation
// - each data byte is stored once bit 8 arrives, finished before acknowledge.
// - no page buffering; every byte goes straight to its address.
// - read-direction target byte starts data from the current address at once.
// - read address advances per byte; the next byte is fetched on the eighth clock, before the master acknowledge.
// - stop or start in the acknowledge clock ends the read; device releases sda.
// - memory address wraps from 7fff to 0000.
// - repeated start after address abandons the write; next read uses it.
// - register writes use their own type code and one address byte.
// - register reads start at current register address and auto-increment.
// - memory and register address latches are independent of each other.
// - memory address two bytes, msb first, unused top bits ignored.
// - type code 1010 selects memory, 1101 selects registers.
// - target byte bits 2-1 must match the two select pins.
// - register address above 18h gets no-acknowledge and aborts.
// - address latch advances after each data byte, before acknowledge.
`timescale 1ns/100ps
`include "twi_target_defs.vh"
module twi_target #(
	parameter MEM_ADDR_BITS = 15,
	parameter MEM_DEPTH = 32768
) (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// bus pins, sda open drain
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	// select pins
	input wire [1:0] sel_pins,
	// register space access for the companion logic
	output reg reg_write,
	output reg [4:0] reg_addr_out,
	output reg [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	// status
	output reg busy
);
	// ****************************************
	// states
	// ****************************************
	localparam ST_IDLE = 3'd0;
	localparam ST_DEVADDR = 3'd1;
	localparam ST_ADDR_HI = 3'd2;
	localparam ST_ADDR_LO = 3'd3;
	localparam ST_WDATA = 3'd4;
	localparam ST_RDATA = 3'd5;
	localparam ST_WAIT = 3'd6;

	wire scl;
	wire sda;
	wire scl_rise;
	wire scl_fall;
	wire start_seen;
	wire stop_seen;
	wire [7:0] mem_rdata;

	reg [2:0] state;
	reg [3:0] bitcnt;
	reg [7:0] shreg;
	reg is_reg;
	reg ack_phase;
	reg ack_drive;
	reg nack_pending;
	reg [MEM_ADDR_BITS-1:0] mem_addr;
	reg [4:0] reg_addr;
	reg [7:0] addr_hi;
	reg mem_write;
	reg [7:0] mem_wdata;
	reg [7:0] tx_byte;
	reg tx_load;
	reg load_is_reg;
	wire [7:0] rx_byte;
	wire dev_match;
	reg dev_match_r;
	reg adv_pending;
	reg [1:0] sel_meta;
	reg [1:0] sel_sync;
	wire [MEM_ADDR_BITS-1:0] mem_addr_new;
	wire [MEM_ADDR_BITS-1:0] mem_next;
	wire [4:0] reg_next;
	wire [15:0] addr_full;

	line_sync u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl(scl),
		.sda(sda),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen)
	);

	byte_store #(
		.ADDR_WIDTH(MEM_ADDR_BITS),
		.DEPTH(MEM_DEPTH)
	) u_store (
		.sys_clk(sys_clk),
		.addr(mem_addr),
		.write(mem_write),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	assign rx_byte = {shreg[6:0], sda};
	assign dev_match = (rx_byte[`SEL_MSB:`SEL_LSB] == sel_sync) &&
		((rx_byte[`TYPE_MSB:`TYPE_LSB] == `MEM_DEVICE_TYPE) ||
		(rx_byte[`TYPE_MSB:`TYPE_LSB] == `REG_DEVICE_TYPE));

	// ****************************************
	// protocol engine
	// ****************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			is_reg <= 1'b0;
			ack_phase <= 1'b0;
			ack_drive <= 1'b0;
			nack_pending <= 1'b0;
			mem_addr <= `MEM_ADDR_RESET;
			reg_addr <= `REG_ADDR_RESET;
			addr_hi <= 8'h00;
			mem_write <= 1'b0;
			mem_wdata <= 8'h00;
			reg_write <= 1'b0;
			reg_wdata <= 8'h00;
			reg_addr_out <= 5'h00;
			tx_byte <= 8'h00;
			tx_load <= 1'b0;
			load_is_reg <= 1'b0;
			dev_match_r <= 1'b0;
			adv_pending <= 1'b0;
			sel_meta <= 2'h0;
			sel_sync <= 2'h0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			busy <= 1'b0;
		end else begin
			mem_write <= 1'b0;
			reg_write <= 1'b0;
			tx_load <= 1'b0;
			reg_addr_out <= reg_addr;
			busy <= (state != ST_IDLE) && (state != ST_WAIT);
			// select pins are board straps, still taken through two flops
			sel_meta <= sel_pins;
			sel_sync <= sel_meta;
			// step the latch on the same clock edge as the cell takes the byte
			if (mem_write) begin
				mem_addr <= mem_next;
			end
			// one cycle after an address move, fetch the fresh byte
			if (tx_load) begin
				tx_byte <= load_is_reg ? reg_rdata : mem_rdata;
			end
			if (start_seen) begin
				// partial byte dropped, pending write abandoned
				state <= ST_DEVADDR;
				bitcnt <= 4'h0;
				nack_pending <= 1'b0;
				ack_phase <= 1'b0;
				ack_drive <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stop_seen) begin
				state <= ST_IDLE;
				ack_phase <= 1'b0;
				nack_pending <= 1'b0;
				ack_drive <= 1'b0;
				sda_oe <= 1'b0;
			end else if (state != ST_IDLE && state != ST_WAIT) begin
				if (scl_rise && !ack_phase) begin
					shreg <= rx_byte;
					bitcnt <= bitcnt + 4'h1;
				end
				if (scl_rise && ack_phase && state == ST_RDATA) begin
					// master acknowledge on a read byte
					if (sda) begin
						nack_pending <= 1'b1;
					end
				end
				if (scl_fall) begin
					if (ack_phase) begin
						// end of ninth clock
						ack_phase <= 1'b0;
						bitcnt <= 4'h0;
						if (nack_pending || (!ack_drive &&
							state != ST_RDATA)) begin
							state <= ST_WAIT;
							sda_oe <= 1'b0;
							nack_pending <= 1'b0;
						end else if (state == ST_RDATA) begin
							// next sequential byte goes out
							sda_oe <= ~tx_byte[7];
							sda_out <= 1'b0;
							shreg <= tx_byte;
						end else begin
							sda_oe <= 1'b0;
						end
						ack_drive <= 1'b0;
					end else if (bitcnt == 4'h8) begin
						ack_phase <= 1'b1;
						if (state == ST_RDATA) begin
							sda_oe <= 1'b0;
						end else begin
							ack_drive <= 1'b1;
							sda_oe <= 1'b1;
							sda_out <= 1'b0;
							case (state)
							ST_DEVADDR: begin
								if (!dev_match_r) begin
									ack_drive <= 1'b0;
									sda_oe <= 1'b0;
								end else if (shreg[`RW_BIT]) begin
									state <= ST_RDATA;
								end else begin
									state <= ST_ADDR_HI;
								end
							end
							ST_ADDR_HI: begin
								if (is_reg) begin
									// one address byte for registers
									if (shreg > `REG_ADDR_LAST) begin
										ack_drive <= 1'b0;
										sda_oe <= 1'b0;
									end else begin
										reg_addr <= shreg[4:0];
										state <= ST_WDATA;
									end
								end else begin
									addr_hi <= shreg;
									state <= ST_ADDR_LO;
								end
							end
							ST_ADDR_LO: begin
								mem_addr <= mem_addr_new;
								state <= ST_WDATA;
							end
							default: begin
								// data byte committed before acknowledge
								if (is_reg) begin
									reg_write <= 1'b1;
									reg_wdata <= shreg;
									reg_addr_out <= reg_addr;
									reg_addr <= reg_next;
								end else begin
									mem_write <= 1'b1;
									mem_wdata <= shreg;
								end
							end
							endcase
						end
					end else if (state == ST_RDATA) begin
						// the rising edge has already shifted the register
						sda_oe <= ~shreg[7];
						sda_out <= 1'b0;
					end
				end
				if (state == ST_DEVADDR && scl_rise && bitcnt == 4'h7) begin
					is_reg <= rx_byte[`TYPE_MSB:`TYPE_LSB] ==
						`REG_DEVICE_TYPE;
					dev_match_r <= dev_match;
					if (dev_match && rx_byte[`RW_BIT]) begin
						// latch the current byte for the read
						tx_load <= 1'b1;
						load_is_reg <= rx_byte[`TYPE_MSB:`TYPE_LSB] ==
							`REG_DEVICE_TYPE;
					end
				end
				if (state == ST_RDATA && scl_rise && bitcnt == 4'h7) begin
					// advance only this space's latch, then prefetch
					if (is_reg) begin
						reg_addr <= reg_next;
					end else begin
						mem_addr <= mem_next;
					end
					adv_pending <= 1'b1;
				end
				if (adv_pending) begin
					adv_pending <= 1'b0;
					tx_load <= 1'b1;
					load_is_reg <= is_reg;
				end
			end
			// read data first bit goes out right after the target ack
			if (ack_phase && scl_fall && state == ST_RDATA &&
				ack_drive && !start_seen && !stop_seen) begin
				sda_oe <= ~tx_byte[7];
				sda_out <= 1'b0;
				shreg <= tx_byte;
			end
		end
	end

	// ****************************************
	// address arithmetic
	// ****************************************
	// upper address bits beyond the array are ignored
	assign addr_full = {addr_hi, shreg};
	assign mem_addr_new = addr_full[MEM_ADDR_BITS-1:0];
	// natural binary wrap at the top of the array
	assign mem_next = mem_addr + {{(MEM_ADDR_BITS-1){1'b0}}, 1'b1};
	// register space wraps back to zero past the last register
	assign reg_next = ({3'h0, reg_addr} == `REG_ADDR_LAST) ? 5'h00 :
		reg_addr + 5'h01;
endmodule

//--- verification/twi_master_model.sv
// bus master model: drives scl, pulls sda low, reads the wire
`timescale 1ns/100ps
module twi_master_model (
	// bus lines
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// ****
	// bit level
	// ****
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// scl stands high between frames; sda only pulled, never driven high
	task bit_io(input logic b, output logic r);
		sda_low = !b;
		#40 scl = 1'b1;
		#40 r = sda;
		#40 scl = 1'b0;
		#40;
	endtask
	task start;
		sda_low = 1'b0;
		#40 scl = 1'b1;
		#40 sda_low = 1'b1;
		#40 scl = 1'b0;
		#40;
	endtask
	task stop;
		sda_low = 1'b1;
		#40 scl = 1'b1;
		#40 sda_low = 1'b0;
		#40;
	endtask
	task wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task rbits(output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
	endtask
	task rbyte(input logic ack, output logic [7:0] d);
		logic r;
		rbits(d);
		bit_io(!ack, r);
	endtask
endmodule

//--- verification/twi_target_sva.sv
// assertions on the pins of the two-wire target port
`timescale 1ns/100ps
module twi_target_sva (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// watched pins
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire reg_write,
	input wire [4:0] reg_addr_out,
	input wire busy
);
	// ****
	// properties
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	drive_low_a: assert property (sda_oe |-> !sda_out)
		else $error("sda driven high");
	reset_idle_a: assert property ($fell(rst) |-> !sda_oe && !busy)
		else $error("active after reset");
	drive_edge_a: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("drive began with scl high");
	write_pulse_a: assert property (reg_write |=> !reg_write)
		else $error("register write too long");
	reg_range_a: assert property (reg_write |-> reg_addr_out <= 5'h18)
		else $error("register write out of range");
	write_busy_a: assert property (reg_write |-> busy)
		else $error("register write while idle");
	start_quiet_a: assert property (scl_in && $past(scl_in) &&
		$fell(sda_in) |=> !sda_oe [*8])
		else $error("drive after start");
	stop_idle_a: assert property (scl_in && $past(scl_in) &&
		$rose(sda_in) |-> ##[1:6] !busy)
		else $error("busy after stop");
	idle_quiet_a: assert property (!busy ##1 !busy |-> !sda_oe)
		else $error("drive while idle");
endmodule
bind twi_target twi_target_sva i_twi_target_sva (.sys_clk, .rst,
	.scl_in, .sda_in, .sda_out, .sda_oe, .reg_write, .reg_addr_out,
	.busy);

//--- verification/twi_target_bench.sv
// self-checking bench for the two-wire target port
`timescale 1ns/100ps
`include "twi_target_defs.vh"
module twi_target_bench;
	// ****
	// set-up
	// ****
	localparam logic [1:0] SEL = 2'h2;
	localparam logic [3:0] MT = `MEM_DEVICE_TYPE;
	localparam logic [3:0] RT = `REG_DEVICE_TYPE;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic sda_out, sda_oe, reg_write, busy, a;
	logic [4:0] reg_addr_out, wa;
	logic [7:0] reg_wdata, wd, d;
	wire scl_in, sda_low;
	wire sda_in = !(sda_low || (sda_oe && !sda_out));
	wire [7:0] reg_rdata = {3'h0, reg_addr_out} ^ 8'ha0;
	int fail_count = 0;
	int cmp_count = 0;
	typedef struct {logic [15:0] wa, ra; logic [7:0] dt;} row_t;
	row_t rows[4] = '{'{16'h0000, 16'h0000, 8'h3c},
		'{16'h1234, 16'h1234, 8'ha5}, '{16'hffff, 16'h7fff, 8'h81},
		'{16'h0100, 16'h0100, 8'h5e}};
	twi_master_model i_twi_master_model (.scl(scl_in), .sda_low,
		.sda(sda_in));
	twi_target i_twi_target (.sys_clk, .rst, .scl_in, .sda_in, .sda_out,
		.sda_oe, .sel_pins(SEL), .reg_write, .reg_addr_out, .reg_wdata,
		.reg_rdata, .busy);
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (reg_write) begin
		wa <= reg_addr_out;
		wd <= reg_wdata;
	end
	task cmp(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task tx(input logic [7:0] b, input logic e);
		i_twi_master_model.wbyte(b, a);
		cmp({7'h0, a}, {7'h0, e});
	endtask
	task go(input logic [3:0] t, input logic rw);
		i_twi_master_model.start();
		tx({t, 1'b0, SEL, rw}, 1'b1);
	endtask
	task setm(input logic [15:0] ad);
		go(MT, 1'b0);
		tx(ad[15:8], 1'b1);
		tx(ad[7:0], 1'b1);
	endtask
	task rd(input logic [7:0] e, input logic ack);
		i_twi_master_model.rbyte(ack, d);
		cmp(d, e);
	endtask
	// ****
	// sequence
	// ****
	initial begin
		repeat (3) @(posedge sys_clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		foreach (rows[i]) begin
			setm(rows[i].wa);
			tx(rows[i].dt, 1'b1);
			i_twi_master_model.stop();
			setm(rows[i].ra);
			go(MT, 1'b1);
			rd(rows[i].dt, 1'b0);
			i_twi_master_model.stop();
		end
		setm(16'h7ffe);
		tx(8'h11, 1'b1);
		tx(8'h22, 1'b1);
		tx(8'h33, 1'b1);
		i_twi_master_model.stop();
		setm(16'h7ffe);
		go(MT, 1'b1);
		rd(8'h11, 1'b1);
		i_twi_master_model.rbits(d);
		cmp(d, 8'h22);
		i_twi_master_model.stop();
		cmp({6'h0, busy, sda_oe}, 8'h00);
		go(RT, 1'b0);
		tx(8'h05, 1'b1);
		tx(8'h9c, 1'b1);
		cmp({3'h0, wa}, 8'h05);
		cmp(wd, 8'h9c);
		tx(8'h47, 1'b1);
		cmp({3'h0, wa}, 8'h06);
		i_twi_master_model.stop();
		go(RT, 1'b1);
		rd(8'ha7, 1'b1);
		rd(8'ha8, 1'b0);
		go(MT, 1'b1);
		rd(8'h33, 1'b0);
		go(RT, 1'b0);
		tx(8'h19, 1'b0);
		i_twi_master_model.stop();
		i_twi_master_model.start();
		tx({MT, 1'b0, ~SEL, 1'b1}, 1'b0);
		i_twi_master_model.stop();
		setm(16'h0100);
		for (int i = 0; i < 5; i++)
			i_twi_master_model.bit_io(1'b0, a);
		go(MT, 1'b1);
		rd(8'h5e, 1'b0);
		i_twi_master_model.stop();
		// reset in mid-run clears the address latch, not the array
		@(posedge sys_clk);
		#1 rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 rst = 1'b0;
		cmp({5'h0, busy, sda_oe, reg_write}, 8'h00);
		repeat (4) @(posedge sys_clk);
		#1;
		go(MT, 1'b1);
		rd(8'h33, 1'b0);
		i_twi_master_model.stop();
		tally_and_finish();
	end
	initial begin
		#1000000;
		fail_count++;
		tally_and_finish();
	end
endmodule
